// [ndc_pkg.sv]
// What this block does
// - Read-multiple select set: master reads use command code 1100.
// - Read-multiple select clear: master reads use command code 0110.
// - Writing one to soft reset bit starts internal reset; bit self-clears.
// - A write to transmit poll register while idle or suspended fetches the current transmit descriptor.
// - Transmit descriptor not owned: transmit process returns to suspended.
// - Transmit descriptor owned: transmit process starts moving buffer data.
// - A write to receive poll register while idle or suspended fetches the current receive descriptor.
// - Receive descriptor not owned: receive process returns to suspended.
// - Receive descriptor owned: receive process starts filling the buffer.
// - Receive ring base holds chain start; first poll after a write made while idle or suspended fetches there.
// - Transmit ring base holds chain start; first poll after a write made while idle or suspended fetches there.
// - Ring bases are held apart from the working pointers; readback returns the last written base.
// - Registers sit on 8-byte steps: control 00H, transmit poll 08H.
// - Hardware and software reset return all these registers to defaults.
package ndc_pkg;
  localparam logic [7:0]  NDC_OFS_SYS_CTRL = 8'h00;
  localparam logic [7:0]  NDC_OFS_TX_POLL  = 8'h08;
  localparam logic [7:0]  NDC_OFS_RX_POLL  = 8'h10;
  localparam logic [7:0]  NDC_OFS_RX_BASE  = 8'h18;
  localparam logic [7:0]  NDC_OFS_TX_BASE  = 8'h20;
  localparam int          NDC_RD_MULT_BIT  = 21;
  localparam int          NDC_SOFT_RST_BIT = 0;
  localparam logic [31:0] NDC_SYS_CTRL_RST = 32'hDE000000;
  localparam logic [31:0] NDC_POLL_RST     = 32'h0FFFFFFF;
  localparam logic [31:0] NDC_BASE_RST     = 32'h00000000;
  localparam logic [3:0]  NDC_CMD_MEM_RD   = 4'h6;
  localparam logic [3:0]  NDC_CMD_MEM_RDM  = 4'hC;
  localparam int          NDC_SRST_CYCLES  = 32;
  localparam logic [31:0] NDC_DESC_STEP    = 32'h00000010;
  localparam int          NDC_OWN_BIT      = 31;

  typedef enum logic [3:0] {
    NDC_ST_IDLE  = 4'b0001,
    NDC_ST_FETCH = 4'b0010,
    NDC_ST_SUSP  = 4'b0100,
    NDC_ST_MOVE  = 4'b1000
  } ndc_proc_e;

  typedef struct packed {
    logic        req;
    logic [3:0]  cmd;
    logic [31:0] addr;
  } ndc_fetch_s;
endpackage

// [ndc_ring_proc.sv]
`timescale 1ns/1ps
`default_nettype none
module ndc_ring_proc
  import ndc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        poll_in,
  input  wire logic        base_wr_in,
  input  wire logic [31:0] base_in,
  input  wire logic [3:0]  cmd_in,
  input  wire logic        fetch_done_in,
  input  wire logic        owned_in,
  input  wire logic        move_done_in,
  output var  ndc_fetch_s  fetch_out,
  output var  ndc_proc_e   state_out
);
  ndc_proc_e   state_q, state_d;
  logic [31:0] ptr_q, ptr_d;
  logic [3:0]  cmd_q, cmd_d;

  always_comb begin
    state_d = state_q;
    ptr_d   = ptr_q;
    cmd_d   = cmd_q;
    if (base_wr_in) begin
      ptr_d = base_in;
    end
    unique case (state_q)
      NDC_ST_IDLE, NDC_ST_SUSP: begin
        if (poll_in) begin
          state_d = NDC_ST_FETCH;
          cmd_d   = cmd_in;
        end
      end
      NDC_ST_FETCH: begin
        if (fetch_done_in) begin
          state_d = owned_in ? NDC_ST_MOVE : NDC_ST_SUSP;
        end
      end
      NDC_ST_MOVE: begin
        if (move_done_in) begin
          state_d = NDC_ST_IDLE;
          // Advance the working pointer; base register readback does not follow it
          if (!base_wr_in) begin
            ptr_d = ptr_q + NDC_DESC_STEP;
          end
        end
      end
      default: state_d = NDC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= NDC_ST_IDLE;
      ptr_q   <= NDC_BASE_RST;
      cmd_q   <= NDC_CMD_MEM_RD;
    end else begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      cmd_q   <= cmd_d;
    end
  end

  assign fetch_out = '{req: (state_q == NDC_ST_FETCH), cmd: cmd_q, addr: ptr_q};
  assign state_out = state_q;

  fetch_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == NDC_ST_FETCH) && !fetch_done_in |=> state_q == NDC_ST_FETCH)
    else $error("fetch left without completion");
  not_owned_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == NDC_ST_FETCH) && fetch_done_in && !owned_in |=> state_q == NDC_ST_SUSP)
    else $error("unowned descriptor did not suspend");
  owned_move_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == NDC_ST_FETCH) && fetch_done_in && owned_in |=> state_q == NDC_ST_MOVE)
    else $error("owned descriptor did not start transfer");
  base_fetch_a: assert property (@(posedge clk_in) disable iff (reset_in)
    base_wr_in ##1 (fetch_out.req && !base_wr_in) |-> fetch_out.addr == $past(base_in, 1))
    else $error("fetch not at written base");
endmodule
`default_nettype wire

// [ndc_dma_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module ndc_dma_ctrl
  import ndc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  output logic             core_reset_out,
  output logic      [3:0]  read_cmd_out,
  output var  ndc_fetch_s  tx_fetch_out,
  output var  ndc_fetch_s  rx_fetch_out,
  input  wire logic        tx_fetch_done_in,
  input  wire logic        tx_owned_in,
  input  wire logic        tx_move_done_in,
  input  wire logic        rx_fetch_done_in,
  input  wire logic        rx_owned_in,
  input  wire logic        rx_move_done_in,
  output var  ndc_proc_e   tx_state_out,
  output var  ndc_proc_e   rx_state_out
);
  logic        rd_mult_q, rd_mult_d;
  logic [5:0]  srst_cnt_q, srst_cnt_d;
  logic        soft_rst_q, soft_rst_d;
  logic [31:0] rx_base_q, rx_base_d;
  logic [31:0] tx_base_q, tx_base_d;
  logic [31:0] rdata_q, rdata_d;
  logic        any_rst;
  logic        wr_ctrl, wr_txp, wr_rxp, wr_rxb, wr_txb;

  // Soft reset clears everything here except its own countdown
  assign any_rst = reset_in | soft_rst_q;
  assign wr_ctrl = reg_wr_in && reg_addr_in == NDC_OFS_SYS_CTRL;
  assign wr_txp  = reg_wr_in && reg_addr_in == NDC_OFS_TX_POLL;
  assign wr_rxp  = reg_wr_in && reg_addr_in == NDC_OFS_RX_POLL;
  assign wr_rxb  = reg_wr_in && reg_addr_in == NDC_OFS_RX_BASE;
  assign wr_txb  = reg_wr_in && reg_addr_in == NDC_OFS_TX_BASE;

  always_comb begin
    rd_mult_d  = rd_mult_q;
    rx_base_d  = rx_base_q;
    tx_base_d  = tx_base_q;
    soft_rst_d = soft_rst_q;
    srst_cnt_d = srst_cnt_q;
    rdata_d    = rdata_q;
    if (soft_rst_q) begin
      // Accesses during the 32-cycle reset are ignored; host must hold off
      srst_cnt_d = srst_cnt_q - 6'h01;
      if (srst_cnt_q == 6'h01) begin
        soft_rst_d = 1'b0;
      end
    end else begin
      if (wr_ctrl) begin
        rd_mult_d = reg_wdata_in[NDC_RD_MULT_BIT];
        if (reg_wdata_in[NDC_SOFT_RST_BIT]) begin
          soft_rst_d = 1'b1;
          srst_cnt_d = 6'(NDC_SRST_CYCLES);
        end
      end
      if (wr_rxb) begin
        rx_base_d = reg_wdata_in;
      end
      if (wr_txb) begin
        tx_base_d = reg_wdata_in;
      end
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          NDC_OFS_SYS_CTRL: rdata_d = NDC_SYS_CTRL_RST
                                      | (32'(rd_mult_q) << NDC_RD_MULT_BIT);
          NDC_OFS_TX_POLL, NDC_OFS_RX_POLL: rdata_d = NDC_POLL_RST;
          NDC_OFS_RX_BASE: rdata_d = rx_base_q;
          NDC_OFS_TX_BASE: rdata_d = tx_base_q;
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      soft_rst_q <= 1'b0;
      srst_cnt_q <= 6'h00;
    end else begin
      soft_rst_q <= soft_rst_d;
      srst_cnt_q <= srst_cnt_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || (soft_rst_q && srst_cnt_q == 6'(NDC_SRST_CYCLES))) begin
      rd_mult_q <= 1'b0;
      rx_base_q <= NDC_BASE_RST;
      tx_base_q <= NDC_BASE_RST;
      rdata_q   <= 32'h00000000;
    end else begin
      rd_mult_q <= rd_mult_d;
      rx_base_q <= rx_base_d;
      tx_base_q <= tx_base_d;
      rdata_q   <= rdata_d;
    end
  end

  assign read_cmd_out   = rd_mult_q ? NDC_CMD_MEM_RDM : NDC_CMD_MEM_RD;
  assign core_reset_out = soft_rst_q;
  assign reg_rdata_out  = rdata_q;

  ndc_ring_proc u_tx (
    .clk_in        (clk_in),
    .reset_in      (any_rst),
    .poll_in       (wr_txp && !soft_rst_q),
    .base_wr_in    (wr_txb && !soft_rst_q),
    .base_in       (reg_wdata_in),
    .cmd_in        (read_cmd_out),
    .fetch_done_in (tx_fetch_done_in),
    .owned_in      (tx_owned_in),
    .move_done_in  (tx_move_done_in),
    .fetch_out     (tx_fetch_out),
    .state_out     (tx_state_out)
  );

  ndc_ring_proc u_rx (
    .clk_in        (clk_in),
    .reset_in      (any_rst),
    .poll_in       (wr_rxp && !soft_rst_q),
    .base_wr_in    (wr_rxb && !soft_rst_q),
    .base_in       (reg_wdata_in),
    .cmd_in        (read_cmd_out),
    .fetch_done_in (rx_fetch_done_in),
    .owned_in      (rx_owned_in),
    .move_done_in  (rx_move_done_in),
    .fetch_out     (rx_fetch_out),
    .state_out     (rx_state_out)
  );

  sequence srst_write_s;
    wr_ctrl && reg_wdata_in[NDC_SOFT_RST_BIT] && !soft_rst_q;
  endsequence

  rd_mult_cmd_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_ctrl && !soft_rst_q && reg_wdata_in[NDC_RD_MULT_BIT] |=> read_cmd_out == 4'hC)
    else $error("read multiple command not chosen");
  // Checked on the fetch itself, not on the mux, so a stale captured command shows
  rd_plain_cmd_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(rx_fetch_out.req) && !$past(rd_mult_q) |-> rx_fetch_out.cmd == NDC_CMD_MEM_RD)
    else $error("plain read command not chosen");
  srst_span_a: assert property (@(posedge clk_in) disable iff (reset_in)
    srst_write_s |=> core_reset_out [*8] ##25 !core_reset_out)
    else $error("soft reset span wrong");
  srst_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
    srst_write_s |-> ##33 (!rd_mult_q && rx_base_q == 32'h0 && tx_base_q == 32'h0))
    else $error("soft reset left registers set");
  tx_poll_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_txp && !soft_rst_q && tx_state_out != NDC_ST_FETCH && tx_state_out != NDC_ST_MOVE
    |=> tx_fetch_out.req)
    else $error("transmit poll did not fetch");
  rx_poll_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_rxp && !soft_rst_q && rx_state_out != NDC_ST_FETCH && rx_state_out != NDC_ST_MOVE
    |=> rx_fetch_out.req)
    else $error("receive poll did not fetch");
  fetch_cmd_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(tx_fetch_out.req) |-> tx_fetch_out.cmd == $past(read_cmd_out))
    else $error("fetch command mismatch");
endmodule
`default_nettype wire

// [ndc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ndc_mem_model
  import ndc_pkg::*;
#(
  parameter int DLY = 0
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  var  ndc_fetch_s fetch_in,
  input  wire logic       own_in,
  output logic            done_out,
  output logic            owned_out,
  output logic            move_done_out
);
  int   cnt;
  int   mv;
  logic flip;
  // Owned flag is only meaningful with done; toggle elsewhere so stale values show
  assign owned_out = done_out ? own_in : flip;
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    move_done_out <= 1'b0;
    flip <= ~flip;
    if (reset_in) begin
      cnt <= 0;
      mv <= 0;
      flip <= 1'b0;
    end else begin
      if (fetch_in.req && !done_out) begin
        if (cnt >= DLY) begin
          done_out <= 1'b1;
          cnt <= 0;
          if (own_in) begin
            mv <= 6;
          end
        end else begin
          cnt <= cnt + 1;
        end
      end
      if (mv == 1) begin
        move_done_out <= 1'b1;
      end
      if (mv > 0) begin
        mv <= mv - 1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ndc_pkg::*;
  logic        clk_in, reset_in, wr_s, rd_s, cr, tgr, rgr;
  logic        tdn, tow, tmv, rdn, row, rmv;
  logic [7:0]  adr;
  logic [31:0] wd, rdat;
  logic [3:0]  rcmd;
  ndc_fetch_s  tf, rf;
  ndc_proc_e   ts, rs;
  int          bad_count, tests_run, n;
  ndc_dma_ctrl dut_u (.clk_in(clk_in), .reset_in(reset_in), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_addr_in(adr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .core_reset_out(cr), .read_cmd_out(rcmd), .tx_fetch_out(tf), .rx_fetch_out(rf),
    .tx_fetch_done_in(tdn), .tx_owned_in(tow), .tx_move_done_in(tmv),
    .rx_fetch_done_in(rdn), .rx_owned_in(row), .rx_move_done_in(rmv),
    .tx_state_out(ts), .rx_state_out(rs));
  // Prompt memory on transmit, slow one on receive
  ndc_mem_model #(.DLY(0)) tm (.clk_in(clk_in), .reset_in(reset_in), .fetch_in(tf),
    .own_in(tgr), .done_out(tdn), .owned_out(tow), .move_done_out(tmv));
  ndc_mem_model #(.DLY(5)) rm (.clk_in(clk_in), .reset_in(reset_in), .fetch_in(rf),
    .own_in(rgr), .done_out(rdn), .owned_out(row), .move_done_out(rmv));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_s <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd_s <= 1'b1;
    adr <= a;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 chk("rdata", e, rdat);
  endtask
  task automatic wst(input logic x, input ndc_proc_e e);
    int k;
    k = 0;
    while ((x ? rs : ts) !== e && k < 40) begin
      @(posedge clk_in);
      #1 k++;
    end
    chk("state", {28'h0, e}, {28'h0, x ? rs : ts});
    // A used-up limit is a failure even if the state arrived on the last look
    if (k == 40) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic poll(input logic x, input logic o, input logic [31:0] a,
                      input logic [3:0] c, input ndc_proc_e e);
    int k;
    ndc_fetch_s f;
    if (x) rgr <= o;
    else tgr <= o;
    wr(x ? NDC_OFS_RX_POLL : NDC_OFS_TX_POLL, 32'hA5A5A5A5);
    k = 0;
    #1 f = x ? rf : tf;
    while (f.req !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      #1 f = x ? rf : tf;
      k++;
    end
    chk("fetch_req", 32'h1, {31'h0, f.req});
    if (k == 20) close_out();
    chk("fetch_addr", a, f.addr);
    chk("fetch_cmd", {28'h0, c}, {28'h0, f.cmd});
    wst(x, e);
  endtask
  initial begin
    {wr_s, rd_s, tgr, rgr} = 4'h0;
    adr = 8'h00;
    wd = 32'h0;
    reset_in = 1'b1;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(NDC_OFS_SYS_CTRL, NDC_SYS_CTRL_RST);
    rd(NDC_OFS_RX_POLL, NDC_POLL_RST);
    rd(NDC_OFS_TX_BASE, NDC_BASE_RST);
    rd(8'h28, 32'h0);
    chk("read_cmd", {28'h0, NDC_CMD_MEM_RD}, {28'h0, rcmd});
    wr(NDC_OFS_SYS_CTRL, 32'h00200000);
    rd(NDC_OFS_SYS_CTRL, NDC_SYS_CTRL_RST | 32'h00200000);
    chk("read_cmd", {28'h0, NDC_CMD_MEM_RDM}, {28'h0, rcmd});
    wr(NDC_OFS_TX_BASE, 32'h00001000);
    poll(0, 0, 32'h1000, NDC_CMD_MEM_RDM, NDC_ST_SUSP);
    poll(0, 1, 32'h1000, NDC_CMD_MEM_RDM, NDC_ST_MOVE);
    wst(0, NDC_ST_IDLE);
    poll(0, 0, 32'h1000 + NDC_DESC_STEP, NDC_CMD_MEM_RDM, NDC_ST_SUSP);
    wr(NDC_OFS_SYS_CTRL, 32'h0);
    wr(NDC_OFS_RX_BASE, 32'h00002000);
    poll(1, 0, 32'h2000, NDC_CMD_MEM_RD, NDC_ST_SUSP);
    poll(1, 1, 32'h2000, NDC_CMD_MEM_RD, NDC_ST_MOVE);
    wst(1, NDC_ST_IDLE);
    rgr <= 1'b0;
    wr(NDC_OFS_RX_POLL, 32'h0);
    wr(NDC_OFS_RX_BASE, 32'h00003000);
    #1 chk("fetch_addr", 32'h00003000, rf.addr);
    wst(1, NDC_ST_SUSP);
    wr(NDC_OFS_SYS_CTRL, 32'h00200001);
    n = 0;
    #1 while (cr !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1 n++;
    end
    n = 0;
    while (cr === 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk("reset_len", NDC_SRST_CYCLES, n);
    rd(NDC_OFS_SYS_CTRL, NDC_SYS_CTRL_RST);
    rd(NDC_OFS_RX_BASE, NDC_BASE_RST);
    poll(0, 0, NDC_BASE_RST, NDC_CMD_MEM_RD, NDC_ST_SUSP);
    close_out();
  end
endmodule
`default_nettype wire
